/* File: design/sei_defs.vh */
// Constants for the interrupt vectoring and external trigger block
// Functional notes
// - Capture all flags once per machine cycle
// - Poll captured flags, call unless priority blocked
// - Vector only in instruction's last cycle
// - After return or enable/priority write, wait one instruction; a call still goes ahead if it comes on the polling tick while blk_q is 0
// - Denied requests are never remembered
// - Higher request preempts during lower call
// - Call pushes PC, loads source vector
// - Fixed vector address per source
// - Clear ext0/ext1 flag only if edge-triggered
// - Return ends level, pops PC, resumes
// - Plain return keeps level in progress
// - Ext0/ext1 type 0 low level, 1 falling
// - Falling edge: high sample then low sample
// - Ext2/ext3 select 0 falling, 1 rising
// - Ext4 to ext6 rising edge only
// - Reload pin falling sets flag if enabled
// - Ext2 to ext6 flags cleared on call
// - Six groups, four levels, 3 highest
// - Same level: group order, leftmost first
// - Hardware call lasts two machine cycles
`ifndef SEI_DEFS_VH
`define SEI_DEFS_VH

`define SEI_NSRC 17
`define SEI_MC_CLKS 12
`define SEI_CALL_MCYC 2
`define SEI_BLK_INSTR 2

// Register word offsets
`define SEI_OFF_ENABLE 4'h0
`define SEI_OFF_PRIO 4'h1
`define SEI_OFF_TRIG 4'h2
`define SEI_OFF_EXTFLAG 4'h3
`define SEI_OFF_STATUS 4'h4

// Fields
`define SEI_ENA_GLOBAL 17
`define SEI_PRIO_HI_LSB 8
`define SEI_TRIG_IT0 0
`define SEI_TRIG_IT1 1
`define SEI_TRIG_EXT2_EDGE_SELECT 2
`define SEI_TRIG_EXT3_EDGE_SELECT 3
`define SEI_TRIG_TIMER2_EXT_RELOAD_ENABLE 4
`define SEI_STAT_CAPT_LSB 8
`define SEI_RST_REG 32'h0000_0000

// Source indices
`define SEI_SRC_EXT0 5'h00
`define SEI_SRC_EXT1 5'h02
`define SEI_SRC_T2 5'h05
`define SEI_SRC_EXT2 5'h07

// Vector addresses
`define SEI_VEC_EXT0 16'h0003
`define SEI_VEC_TF0 16'h000b
`define SEI_VEC_EXT1 16'h0013
`define SEI_VEC_TF1 16'h001b
`define SEI_VEC_SER0 16'h0023
`define SEI_VEC_T2 16'h002b
`define SEI_VEC_ADC 16'h0043
`define SEI_VEC_EXT2 16'h004b
`define SEI_VEC_EXT_STEP 16'h0008
`define SEI_VEC_SER1 16'h0083
`define SEI_VEC_CMP 16'h0093
`define SEI_VEC_CTF 16'h009b
`define SEI_VEC_ICS 16'h00a3
`define SEI_VEC_ICR 16'h00ab

`endif

/* File: design/sei_pin_edge.v */
// Per-machine-cycle pin sampler with edge detector
`timescale 1ns/1ns
`default_nettype none
module sei_pin_edge (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire tick_i,
  input wire pin_i,
  input wire rise_sel_i,
  output wire edge_o,
  output wire low_o
);
  reg cur_q;
  reg prev_q;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cur_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (tick_i) begin
      cur_q <= pin_i;
      prev_q <= cur_q;
    end
  end

  // Two successive samples differ in the selected direction
  assign edge_o = tick_i & (rise_sel_i ? (~prev_q & cur_q) : (prev_q & ~cur_q));
  assign low_o = ~cur_q;
endmodule
`default_nettype wire

/* File: design/sei_arb.v */
// Level and polling-order arbiter for seventeen sources
`timescale 1ns/1ns
`default_nettype none
module sei_arb (
  input wire [16:0] req_i,
  input wire [5:0] prio_lo_i,
  input wire [5:0] prio_hi_i,
  output reg valid_o,
  output reg [4:0] idx_o,
  output reg [1:0] lvl_o
);
  // Group of each source
  function [2:0] grp;
    input [4:0] s;
    begin
      if (s < 5'd6)
        grp = s[2:0];
      else if (s < 5'd12)
        grp = s[2:0] - 3'd6;
      else if (s == 5'd12)
        grp = 3'd0;
      else
        grp = s[2:0] - 3'd3;
    end
  endfunction

  // Place inside group: 0 left, 2 right
  function [1:0] pos;
    input [4:0] s;
    begin
      if (s < 5'd6)
        pos = 2'd0;
      else if (s < 5'd12)
        pos = 2'd2;
      else
        pos = 2'd1;
    end
  endfunction

  integer i;
  reg [4:0] ord;
  reg [4:0] best_ord;
  reg [1:0] l;
  reg [2:0] g;

  always @* begin
    valid_o = 1'b0;
    idx_o = 5'h00;
    lvl_o = 2'h0;
    best_ord = 5'h1f;
    ord = 5'h00;
    l = 2'h0;
    g = 3'h0;
    for (i = 0; i < 17; i = i + 1) begin
      g = grp(i[4:0]);
      l = {prio_hi_i[g], prio_lo_i[g]};
      ord = 5'd3 * {2'b00, g} + {3'b000, pos(i[4:0])};
      if (req_i[i] && (!valid_o || l > lvl_o || (l == lvl_o && ord < best_ord))) begin
        valid_o = 1'b1;
        idx_o = i[4:0];
        lvl_o = l;
        best_ord = ord;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/sei_intc.v */
// Interrupt vectoring controller with external trigger logic
`timescale 1ns/1ns
`default_nettype none
`include "sei_defs.vh"
module sei_intc #(
  parameter MC_CLKS = `SEI_MC_CLKS
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  // Avalon-MM slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Core sequencer
  input wire instr_last_i,
  input wire instr_blocking_i,
  input wire return_from_interrupt_i,
  output wire flag_sample_phase_o,
  output wire hw_vector_call_o,
  output wire call_busy_o,
  output wire [15:0] vec_addr_o,
  output wire [4:0] vec_src_o,
  output wire pop_pc_o,
  output wire [3:0] level_active_o,
  // Pins, active low for ext0/ext1
  input wire ext0_request_pin_n_i,
  input wire ext1_request_pin_n_i,
  input wire [4:0] ext26_request_pin_i,
  input wire timer2_reload_trigger_pin_i,
  // Peripheral flags, bits for ext sources ignored
  input wire [16:0] periph_flags_i
);
  reg [4:0] div_q;
  reg [31:0] rdata_q;
  reg ack_q;
  reg [17:0] ena_q;
  reg [5:0] prio_lo_q;
  reg [5:0] prio_hi_q;
  reg [4:0] trig_q;
  reg [7:0] ext_flag_q;
  reg [7:0] ext_flag_d;
  reg [16:0] smp_q;
  reg [3:0] inprog_q;
  reg [1:0] blk_q;
  reg [1:0] call_q;
  reg call_p_q;
  reg pop_q;
  reg [15:0] vec_addr_q;
  reg [4:0] vec_src_q;
  wire tick;
  wire [7:0] pins;
  wire [7:0] rise_sel;
  wire [7:0] pin_edge;
  wire [7:0] pin_low;
  wire [16:0] flags;
  wire [16:0] pend;
  wire arb_valid;
  wire [4:0] arb_idx;
  wire [1:0] arb_lvl;
  wire [1:0] cur_lvl;
  wire any_prog;
  wire lvl_ok;
  wire slot_ok;
  wire blk_dec;
  wire blk_ok;
  wire do_call;
  wire wr_ack;
  wire blk_set;
  wire [7:0] vec_clr;

  // Counts sized to the registers that load them
  localparam [1:0] CALL_MCYC = `SEI_CALL_MCYC;
  localparam [1:0] BLK_INSTR = `SEI_BLK_INSTR;

  // Machine cycle divider; the tick is the sampling phase
  assign tick = (div_q == MC_CLKS[4:0] - 5'd1);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      div_q <= 5'h00;
    else if (tick)
      div_q <= 5'h00;
    else
      div_q <= div_q + 5'd1;
  end

  // Pin order: ext0, ext1, ext2..ext6, reload trigger
  assign pins = {timer2_reload_trigger_pin_i, ext26_request_pin_i,
                 ext1_request_pin_n_i, ext0_request_pin_n_i};
  assign rise_sel = {1'b0, 3'b111, trig_q[`SEI_TRIG_EXT3_EDGE_SELECT],
                     trig_q[`SEI_TRIG_EXT2_EDGE_SELECT], 2'b00};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      sei_pin_edge u_edge (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick),
        .pin_i(pins[gi]),
        .rise_sel_i(rise_sel[gi]),
        .edge_o(pin_edge[gi]),
        .low_o(pin_low[gi])
      );
    end
  endgenerate

  // Avalon slave: one wait cycle, then answer
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o = rdata_q;
  assign wr_ack = avs_write_i & ack_q;
  assign blk_set = instr_blocking_i | return_from_interrupt_i |
                   (wr_ack & (avs_address_i == `SEI_OFF_ENABLE ||
                              avs_address_i == `SEI_OFF_PRIO));

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= `SEI_RST_REG;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      if (avs_read_i && !ack_q) begin
        case (avs_address_i)
          `SEI_OFF_ENABLE: rdata_q <= {14'h0000, ena_q};
          `SEI_OFF_PRIO: rdata_q <= {18'h00000, prio_hi_q, 2'b00, prio_lo_q};
          `SEI_OFF_TRIG: rdata_q <= {27'h0000000, trig_q};
          `SEI_OFF_EXTFLAG: rdata_q <= {24'h000000, ext_flag_q};
          `SEI_OFF_STATUS: rdata_q <= {7'h00, smp_q, 4'h0, inprog_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ena_q <= 18'h00000;
      prio_lo_q <= 6'h00;
      prio_hi_q <= 6'h00;
      trig_q <= 5'h00;
    end else if (wr_ack) begin
      case (avs_address_i)
        `SEI_OFF_ENABLE: ena_q <= avs_writedata_i[17:0];
        `SEI_OFF_PRIO: begin
          prio_lo_q <= avs_writedata_i[5:0];
          prio_hi_q <= avs_writedata_i[`SEI_PRIO_HI_LSB+5:`SEI_PRIO_HI_LSB];
        end
        `SEI_OFF_TRIG: trig_q <= avs_writedata_i[4:0];
        default: ;
      endcase
    end
  end

  // Flags cleared by the call: edge ext0/ext1 and ext2..ext6
  assign vec_clr[0] = do_call & (arb_idx == `SEI_SRC_EXT0) & trig_q[`SEI_TRIG_IT0];
  assign vec_clr[1] = do_call & (arb_idx == `SEI_SRC_EXT1) & trig_q[`SEI_TRIG_IT1];
  generate
    for (gi = 2; gi < 7; gi = gi + 1) begin : g_clr
      assign vec_clr[gi] = do_call & (arb_idx == `SEI_SRC_EXT2 + gi - 2);
    end
  endgenerate
  assign vec_clr[7] = 1'b0;

  // Software writes first, then call clears, hardware sets win
  always @* begin
    ext_flag_d = ext_flag_q;
    if (wr_ack && avs_address_i == `SEI_OFF_EXTFLAG)
      ext_flag_d = avs_writedata_i[7:0];
    ext_flag_d = ext_flag_d & ~vec_clr;
    ext_flag_d = ext_flag_d | (pin_edge & {trig_q[`SEI_TRIG_TIMER2_EXT_RELOAD_ENABLE], 5'h1f,
                                           trig_q[`SEI_TRIG_IT1], trig_q[`SEI_TRIG_IT0]});
    if (!trig_q[`SEI_TRIG_IT0])
      ext_flag_d[0] = pin_low[0];
    if (!trig_q[`SEI_TRIG_IT1])
      ext_flag_d[1] = pin_low[1];
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      ext_flag_q <= 8'h00;
    else
      ext_flag_q <= ext_flag_d;
  end

  // Request flags in polling index order; external ones come from this block
  assign flags[0] = ext_flag_q[0];
  assign flags[1] = periph_flags_i[1];
  assign flags[2] = ext_flag_q[1];
  assign flags[3] = periph_flags_i[3];
  assign flags[4] = periph_flags_i[4];
  assign flags[5] = periph_flags_i[5] | ext_flag_q[7];
  assign flags[6] = periph_flags_i[6];
  assign flags[7] = ext_flag_q[2];
  assign flags[8] = ext_flag_q[3];
  assign flags[9] = ext_flag_q[4];
  assign flags[10] = ext_flag_q[5];
  assign flags[11] = ext_flag_q[6];
  assign flags[12] = periph_flags_i[12];
  assign flags[13] = periph_flags_i[13];
  assign flags[14] = periph_flags_i[14];
  assign flags[15] = periph_flags_i[15];
  assign flags[16] = periph_flags_i[16];

  // Capture at the sampling phase, poll during the next cycle
  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      smp_q <= 17'h00000;
    else if (tick)
      smp_q <= flags;
  end

  // Only what is captured now is considered
  assign pend = smp_q & ena_q[16:0] & {17{ena_q[`SEI_ENA_GLOBAL]}};

  sei_arb u_arb (
    .req_i(pend),
    .prio_lo_i(prio_lo_q),
    .prio_hi_i(prio_hi_q),
    .valid_o(arb_valid),
    .idx_o(arb_idx),
    .lvl_o(arb_lvl)
  );

  assign any_prog = |inprog_q;
  assign cur_lvl = inprog_q[3] ? 2'd3 : inprog_q[2] ? 2'd2 : inprog_q[1] ? 2'd1 : 2'd0;
  assign lvl_ok = !any_prog || (arb_lvl > cur_lvl);
  // Last call cycle counts as an instruction end for preemption
  assign slot_ok = (call_q == 2'd1) || (call_q == 2'd0 && instr_last_i);
  assign blk_dec = tick && slot_ok && blk_q != 2'd0;
  assign blk_ok = (blk_q == 2'd0) || (blk_q == 2'd1 && blk_dec && !blk_set);
  assign do_call = tick & arb_valid & lvl_ok & slot_ok & blk_ok;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      blk_q <= 2'd0;
    else if (blk_set)
      blk_q <= BLK_INSTR;
    else if (blk_dec)
      blk_q <= blk_q - 2'd1;
  end

  // Call sequencer: call pulse and two-cycle busy count
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      call_q <= 2'd0;
      call_p_q <= 1'b0;
      pop_q <= 1'b0;
    end else begin
      call_p_q <= do_call;
      pop_q <= return_from_interrupt_i & any_prog;
      if (do_call)
        call_q <= CALL_MCYC;
      else if (tick && call_q != 2'd0)
        call_q <= call_q - 2'd1;
    end
  end

  // Vector of the called source, held until the next call
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      vec_addr_q <= 16'h0000;
      vec_src_q <= 5'h00;
    end else if (do_call) begin
      vec_src_q <= arb_idx;
      vec_addr_q <= vec_of(arb_idx);
    end
  end

  // In-progress bit per level: set by a call, cleared by a return
  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      inprog_q <= 4'h0;
    else if (do_call)
      inprog_q[arb_lvl] <= 1'b1;
    else if (return_from_interrupt_i && any_prog)
      inprog_q[cur_lvl] <= 1'b0;
  end

  function [15:0] vec_of;
    input [4:0] s;
    begin
      case (s)
        5'd0: vec_of = `SEI_VEC_EXT0;
        5'd1: vec_of = `SEI_VEC_TF0;
        5'd2: vec_of = `SEI_VEC_EXT1;
        5'd3: vec_of = `SEI_VEC_TF1;
        5'd4: vec_of = `SEI_VEC_SER0;
        5'd5: vec_of = `SEI_VEC_T2;
        5'd6: vec_of = `SEI_VEC_ADC;
        5'd7, 5'd8, 5'd9, 5'd10, 5'd11:
          vec_of = `SEI_VEC_EXT2 + `SEI_VEC_EXT_STEP * {11'h000, s - 5'd7};
        5'd12: vec_of = `SEI_VEC_SER1;
        5'd13: vec_of = `SEI_VEC_CMP;
        5'd14: vec_of = `SEI_VEC_CTF;
        5'd15: vec_of = `SEI_VEC_ICS;
        5'd16: vec_of = `SEI_VEC_ICR;
        default: vec_of = 16'h0000;
      endcase
    end
  endfunction

  assign flag_sample_phase_o = tick;
  assign hw_vector_call_o = call_p_q;
  assign call_busy_o = call_q != 2'd0;
  assign vec_addr_o = vec_addr_q;
  assign vec_src_o = vec_src_q;
  assign pop_pc_o = pop_q;
  assign level_active_o = inprog_q;
endmodule
`default_nettype wire

/* File: sim/sei_intc_props.sv */
// Assertion checker for the interrupt vectoring controller
`timescale 1ns/1ns
`default_nettype none
module sei_intc_props #(
  parameter MC_CLKS = 12
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic instr_last_i,
  input wire logic return_from_interrupt_i,
  input wire logic flag_sample_phase_o,
  input wire logic hw_vector_call_o,
  input wire logic call_busy_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic pop_pc_o,
  input wire logic [3:0] level_active_o
);
  logic [4:0] gap_q;
  logic [4:0] since_q;
  logic [1:0] bt_q;
  logic seen_q;
  // Clocks between phases, clocks since return, phases within a call
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gap_q <= 5'h00;
      since_q <= 5'h1f;
      bt_q <= 2'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= flag_sample_phase_o ? 5'h00 : gap_q + 5'h01;
      seen_q <= seen_q | flag_sample_phase_o;
      since_q <= return_from_interrupt_i ? 5'h00 : since_q + {4'h0, since_q != 5'h1f};
      bt_q <= (hw_vector_call_o || !call_busy_o) ? 2'h0 : bt_q + {1'b0, flag_sample_phase_o};
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_TICK_GAP: assert property (flag_sample_phase_o && seen_q |-> gap_q == MC_CLKS - 1)
    else $error("sample phase spacing wrong");
  AST_CALL_ON_TICK: assert property (hw_vector_call_o |-> $past(flag_sample_phase_o))
    else $error("call not after a sample phase");
  AST_CALL_SLOT: assert property (hw_vector_call_o |-> $past(instr_last_i) || $past(call_busy_o))
    else $error("call in mid instruction");
  AST_RETURN_FROM_INTERRUPT_BLOCK: assert property (hw_vector_call_o |-> since_q >= MC_CLKS - 1)
    else $error("call too soon after return");
  AST_VEC_FORM: assert property (hw_vector_call_o |-> vec_addr_o[2:0] == 3'h3 && vec_addr_o <= 16'h00ab)
    else $error("vector address malformed");
  AST_VEC_HOLD: assert property (!hw_vector_call_o |-> $stable(vec_addr_o))
    else $error("vector changed without a call");
  AST_TOP_LEVEL: assert property (hw_vector_call_o |-> !$past(level_active_o[3], 2))
    else $error("call while top level in progress");
  AST_POP_ON_RETURN_FROM_INTERRUPT: assert property (return_from_interrupt_i && level_active_o != 4'h0 |=> pop_pc_o)
    else $error("return did not pop");
  AST_BUSY_LEN: assert property ($fell(call_busy_o) |-> bt_q == 2'h2)
    else $error("call length not two cycles");
  COV_CALL: cover property (hw_vector_call_o);
  COV_POP: cover property (pop_pc_o);
  COV_CALL_END: cover property ($fell(call_busy_o));
  COV_PREEMPT: cover property (hw_vector_call_o && $past(call_busy_o, 2));
endmodule
`default_nettype wire

/* File: sim/sei_core_model.sv */
// Core sequencer model: instruction ends, return pulses and the PC stack
`timescale 1ns/1ns
`default_nettype none
module sei_core_model #(
  parameter LEN = 2
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic call_i,
  input wire logic busy_i,
  input wire logic pop_i,
  input wire logic return_from_interrupt_req_i,
  input wire logic [15:0] vec_i,
  output logic instr_last_o,
  output logic return_from_interrupt_o,
  output logic [15:0] pc_o
);
  logic [1:0] cyc_q;
  logic [2:0] sp_q;
  logic [15:0] stk_q [0:7];
  assign instr_last_o = (cyc_q == 2'(LEN - 1)) && !busy_i;
  always @(posedge clk_sys_i) begin
    return_from_interrupt_o <= 1'b0;
    if (sys_rst_i) begin
      cyc_q <= 2'h0;
      sp_q <= 3'h0;
      pc_o <= 16'h0100;
    end else begin
      if (tick_i && !busy_i) cyc_q <= instr_last_o ? 2'h0 : cyc_q + 2'h1;
      if (tick_i && instr_last_o) begin
        pc_o <= pc_o + 16'h0001;
        return_from_interrupt_o <= return_from_interrupt_req_i;
      end
      if (call_i) begin
        stk_q[sp_q] <= pc_o;
        sp_q <= sp_q + 3'h1;
        pc_o <= vec_i;
      end
      if (pop_i) begin
        pc_o <= stk_q[sp_q - 3'h1];
        sp_q <= sp_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/sei_intc_tb.sv */
// Testbench for the interrupt vectoring controller
`timescale 1ns/1ns
`default_nettype none
module sei_intc_tb;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [16:0] periph_q = 17'h0;
  logic [6:0] pv = 7'h63;
  logic return_from_interrupt_req = 1'b0;
  logic [31:0] rdata;
  logic [15:0] vec;
  logic [15:0] pc;
  logic [3:0] lvl;
  logic wreq, last, return_from_interrupt, tick, call, busy, pop;
  int num_errors = 0;
  int compares = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  sei_intc #(.MC_CLKS(4)) u_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .instr_last_i(last),
    .instr_blocking_i(1'b0), .return_from_interrupt_i(return_from_interrupt), .flag_sample_phase_o(tick),
    .hw_vector_call_o(call), .call_busy_o(busy), .vec_addr_o(vec), .vec_src_o(),
    .pop_pc_o(pop), .level_active_o(lvl), .ext0_request_pin_n_i(pv[5]),
    .ext1_request_pin_n_i(1'b1), .ext26_request_pin_i(pv[4:0]),
    .timer2_reload_trigger_pin_i(pv[6]), .periph_flags_i(periph_q));
  sei_core_model u_core (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tick_i(tick), .call_i(call),
    .busy_i(busy), .pop_i(pop), .return_from_interrupt_req_i(return_from_interrupt_req), .vec_i(vec),
    .instr_last_o(last), .return_from_interrupt_o(return_from_interrupt), .pc_o(pc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write when w is high, otherwise read and compare with d
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_sys_i);
    while (wreq !== 1'b0) @(posedge clk_sys_i);
    if (!w) chk(rdata, d);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic pulse(input int w);
    pv[w] <= ~pv[w];
    repeat (8) @(posedge clk_sys_i);
    pv[w] <= ~pv[w];
    @(posedge clk_sys_i);
  endtask
  task automatic wcall(input logic [15:0] v);
    int n;
    n = 0;
    while (call !== 1'b1 && n < 400) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk({31'h0, call}, 32'h1);
    chk({16'h0, vec}, {16'h0, v});
    @(posedge clk_sys_i);
    chk({16'h0, pc}, {16'h0, v});
  endtask
  // Return and check the levels still in progress afterwards
  task automatic do_return_from_interrupt_lvl(input logic [3:0] l);
    int n;
    n = 0;
    return_from_interrupt_req <= 1'b1;
    while (pop !== 1'b1 && n < 400) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk({31'h0, pop}, 32'h1);
    return_from_interrupt_req <= 1'b0;
    @(posedge clk_sys_i);
    chk({28'h0, lvl}, {28'h0, l});
  endtask
  task automatic do_return_from_interrupt;
    do_return_from_interrupt_lvl(4'h0);
  endtask
  task automatic s_regs;
    bus(0, 4'h0, 32'h0);
    bus(1, 4'h1, 32'h3f3f);
    bus(0, 4'h1, 32'h3f3f);
    bus(1, 4'h1, 32'h0);
    bus(1, 4'h4, 32'hffff);
    bus(0, 4'h4, 32'h0);
    bus(1, 4'h9, 32'h1);
    bus(0, 4'h9, 32'h0);
    bus(1, 4'h0, 32'h3ffff);
  endtask
  task automatic s_ext0;
    pv[5] <= 1'b0;
    wcall(16'h0003);
    bus(0, 4'h3, 32'h1);
    pv[5] <= 1'b1;
    do_return_from_interrupt;
    bus(1, 4'h2, 32'h1);
    pulse(5);
    wcall(16'h0003);
    bus(0, 4'h3, 32'h0);
    do_return_from_interrupt;
  endtask
  task automatic s_ext26;
    bus(1, 4'h2, 32'h8);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      wcall(16'h004b + 16'(8 * i));
      bus(0, 4'h3, 32'h0);
      do_return_from_interrupt;
    end
  endtask
  task automatic s_reload;
    pulse(6);
    bus(0, 4'h3, 32'h0);
    bus(1, 4'h2, 32'h18);
    pulse(6);
    wcall(16'h002b);
    bus(1, 4'h3, 32'h0);
    do_return_from_interrupt;
  endtask
  task automatic s_prio;
    int n;
    n = 0;
    periph_q <= 17'h01002;
    wcall(16'h0083);
    periph_q <= 17'h00002;
    repeat (32) begin
      @(posedge clk_sys_i);
      if (call === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    do_return_from_interrupt;
    wcall(16'h000b);
    periph_q <= 17'h0;
    do_return_from_interrupt;
  endtask
  // Level 3 timer 0 request arrives while a level 0 call runs
  task automatic s_preempt;
    int n;
    n = 0;
    bus(1, 4'h1, 32'h0202);
    periph_q <= 17'h01000;
    wcall(16'h0083);
    periph_q <= 17'h00002;
    while (call !== 1'b1 && n < 400) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(32'(n), 32'd7);
    wcall(16'h000b);
    periph_q <= 17'h0;
    do_return_from_interrupt_lvl(4'h1);
    chk({16'h0, pc}, 32'h0083);
    do_return_from_interrupt;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    s_regs;
    s_ext0;
    s_ext26;
    s_reload;
    s_prio;
    s_preempt;
    tally_and_finish;
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    num_errors++;
    tally_and_finish;
  end
endmodule
bind sei_intc sei_intc_props #(.MC_CLKS(MC_CLKS)) u_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .instr_last_i(instr_last_i),
  .return_from_interrupt_i(return_from_interrupt_i), .flag_sample_phase_o(flag_sample_phase_o),
  .hw_vector_call_o(hw_vector_call_o), .call_busy_o(call_busy_o), .vec_addr_o(vec_addr_o),
  .pop_pc_o(pop_pc_o), .level_active_o(level_active_o));
`default_nettype wire
